// ### branch_seq_pkg.sv
package branch_seq_pkg;

  // ****************************************************
  // Processor timing slots
  // ****************************************************
  localparam int SLOT_W = 4;
  localparam logic [3:0] SLOT_FIRST = 4'h0;
  localparam logic [3:0] SLOT_FETCH = 4'hb;
  localparam logic [3:0] SLOT_EXEC = 4'hc;
  localparam logic [3:0] SLOT_CLEAR = 4'hd;
  localparam logic [3:0] SLOT_STEP = 4'he;
  localparam logic [3:0] SLOT_LAST = 4'hf;
  // Inhibited slots of one sequence: three of the first cycle plus two full cycles
  localparam logic [5:0] SEQ_INHIBIT_SLOTS = 6'h23;

  // ****************************************************
  // Widths of the instruction latches and address
  // ****************************************************
  localparam int ADDR_W = 12;
  localparam int NIB_W = 4;
  localparam int HIGH_W = 5;
  localparam int CONST_W = 13;

  // ****************************************************
  // Instruction codes
  // ****************************************************
  localparam logic [7:0] OP_HALT = 8'h00;
  localparam logic [7:0] OP_TRDY_SET = 8'hb0;
  localparam logic [7:0] OP_TRDY_CLR = 8'hb1;
  localparam logic [7:0] OP_TXEN_ON = 8'hb2;
  localparam logic [7:0] OP_TXEN_OFF = 8'hb3;
  localparam logic [7:0] OP_ERRD_SET = 8'hb7;
  localparam logic [7:0] OP_VARI_SET = 8'hba;
  localparam logic [7:0] OP_VARI_CLR = 8'hbb;
  localparam logic [7:0] OP_ERRD_CLR = 8'hbf;
  localparam logic [3:0] GRP_BRANCH = 4'h9;
  localparam logic [3:0] GRP_PRINT = 4'hb;
  localparam logic [3:0] DIG_UNCOND = 4'h0;
  localparam logic [3:0] DIG_LOAD_A = 4'he;
  localparam logic [3:0] DIG_LOAD_C = 4'hf;

  // ****************************************************
  // Reset values
  // ****************************************************
  localparam logic RST_TRDY = 1'b0;
  localparam logic RST_VARI = 1'b0;
  localparam logic RST_TXEN_N = 1'b1;
  localparam logic RST_ERRD = 1'b0;
  localparam logic [ADDR_W-1:0] RST_ADDR = 12'h000;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_FIRST, SEQ_SECOND, SEQ_THIRD} seq_stage_t;

endpackage

// ### pin_sync.sv
`timescale 1ns/1ps
// Three-stage synchroniser; a bit changes once stages two and three agree
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] stable
);

  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;

  // First stage feeds only the second; agreement filters one-cycle glitches
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      stable <= '0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      stable <= (s3 & ~(s2 ^ s3)) | (stable & (s2 ^ s3));
    end
  end

endmodule

// ### microcode_branch_sequencer.sv
`timescale 1ns/1ps
// Contract
// - B0 sets, B1 clears transmit ready at T12
// - BA sets, BB clears variable-field inhibit at T12
// - B2 asserts, B3 removes low transmit enable
// - B7 sets, BF clears error display at T12
// - Any Bx drives printer enable active at T12
// - 90..9D branch; low digit picks test condition
// - 9E loads A constant, 9F loads C
// - Second word low eight, third word upper bits
// - Branch or constant takes exactly three cycles
// - 9x loads sequencer, latches digit, inhibits decoder
// - Sequencer advances at each cycle's first slot
// - Second cycle increments, loads low and middle
// - Third cycle blocks low/middle, loads high T11
// - Passing test inhibits increment T12; constant earlier
// - Taken branch clears counter T13, loads T14
// - Address source selects latches from third T12
// - Constant leaves counter, clears A/C at T13
// - Constant path selected third cycle, load T14
// - Latches: two four-bit plus five-bit high
// - Normal instruction loaded at T11, executed same cycle
// - Counter increments at T14 unless inhibited
// - Otherwise address source selects the front panel
// - Code 00 stops the timing counter
module microcode_branch_sequencer
  import branch_seq_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] romData,
  input wire logic [15:0] testCond,
  input wire logic [ADDR_W-1:0] panelAddr,
  input wire logic panelLoad,
  input wire logic panelRun,
  output logic [ADDR_W-1:0] romAddr,
  output logic [7:0] instruction,
  output logic [SLOT_W-1:0] timeSlot,
  output logic halted,
  output logic transmitReadyFlag,
  output logic variableFieldInhibit,
  output logic transmitEnable_n,
  output logic errorDisplayEnable,
  output logic printerEnable_n,
  output logic decoderInhibit,
  output logic thirdCycleLatchBlock_n,
  output logic highLatchLoad,
  output logic incrementInhibit,
  output logic seqAddrClear,
  output logic seqAddrLoad,
  output logic addrSourceSelect_n,
  output logic aConstantClear,
  output logic cConstantClear,
  output logic aConstantLoad,
  output logic cConstantLoad,
  output logic constantPathSelect,
  output logic [CONST_W-1:0] constantValue
);

  // ****************************************************
  // Front panel inputs
  // ****************************************************
  logic [ADDR_W-1:0] panelAddrS;
  logic panelLoadS;
  logic panelRunS;
  logic panelLoadD;
  logic panelRunD;
  logic panelLoadEv;
  logic panelRunEv;

  // Panel switches are asynchronous to the processor clock
  pin_sync #(
    .WIDTH(ADDR_W + 2)
  ) u_panel_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .pin({panelRun, panelLoad, panelAddr}),
    .stable({panelRunS, panelLoadS, panelAddrS})
  );

  // Switch presses act once on their rising edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      panelLoadD <= 1'b0;
      panelRunD <= 1'b0;
    end else begin
      panelLoadD <= panelLoadS;
      panelRunD <= panelRunS;
    end
  end
  assign panelLoadEv = panelLoadS & ~panelLoadD;
  assign panelRunEv = panelRunS & ~panelRunD;

  // ****************************************************
  // Timing counter
  // ****************************************************
  logic run;
  logic firstTimeSlot;
  logic irValid;
  logic [NIB_W-1:0] irLow;
  logic [NIB_W-1:0] irMid;
  logic [HIGH_W-1:0] irHigh;
  seq_stage_t stage;
  logic [3:0] condDigit;
  logic execSlot;
  logic isConst;
  logic testPass;
  logic takenBranch;
  logic [ADDR_W-1:0] addrMux;

  assign run = ~halted;
  // Last slot ends the cycle; the next edge starts the first time slot
  assign firstTimeSlot = run && (timeSlot == SLOT_LAST);

  // Slots stop while halted; a panel run press restarts from where it froze
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timeSlot <= SLOT_FIRST;
    end else if (run) begin
      timeSlot <= timeSlot + 4'h1;
    end
  end

  // Decoded halt freezes the processor until the panel restarts it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      halted <= 1'b0;
    end else if (execCode(OP_HALT)) begin
      halted <= 1'b1;
    end else if (panelRunEv) begin
      halted <= 1'b0;
    end
  end

  // ****************************************************
  // Instruction register
  // ****************************************************
  assign instruction = {irMid, irLow};
  assign constantValue = {irHigh, irMid, irLow};

  // Decoded codes act only at T12 of a running, non-inhibited cycle
  function automatic logic execCode(input logic [7:0] code);
    return execSlot && (instruction == code);
  endfunction

  assign execSlot = run && irValid && !decoderInhibit && (timeSlot == SLOT_EXEC);

  // Low and middle latch each T11 except in the third sequence cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irLow <= '0;
      irMid <= '0;
      irValid <= 1'b0;
    end else if (run && (timeSlot == SLOT_FETCH) && thirdCycleLatchBlock_n) begin
      irLow <= romData[3:0];
      irMid <= romData[7:4];
      irValid <= 1'b1;
    end
  end

  // High latch holds only the upper bits of a target or constant
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irHigh <= '0;
    end else if (highLatchLoad) begin
      irHigh <= romData[HIGH_W-1:0];
    end
  end

  assign highLatchLoad = run && (stage == SEQ_THIRD) && (timeSlot == SLOT_FETCH);
  assign thirdCycleLatchBlock_n = (stage != SEQ_THIRD);

  // ****************************************************
  // Single-code control flags
  // ****************************************************
  // One code per cycle, so set and clear never meet
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      transmitReadyFlag <= RST_TRDY;
    end else if (execCode(OP_TRDY_SET)) begin
      transmitReadyFlag <= 1'b1;
    end else if (execCode(OP_TRDY_CLR)) begin
      transmitReadyFlag <= 1'b0;
    end
  end

  // Variable-field inhibit toward refresh storage control
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      variableFieldInhibit <= RST_VARI;
    end else if (execCode(OP_VARI_SET)) begin
      variableFieldInhibit <= 1'b1;
    end else if (execCode(OP_VARI_CLR)) begin
      variableFieldInhibit <= 1'b0;
    end
  end

  // Transmit enable is active low toward the transmit/receive board
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      transmitEnable_n <= RST_TXEN_N;
    end else if (execCode(OP_TXEN_ON)) begin
      transmitEnable_n <= 1'b0;
    end else if (execCode(OP_TXEN_OFF)) begin
      transmitEnable_n <= 1'b1;
    end
  end

  // Error display enable
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      errorDisplayEnable <= RST_ERRD;
    end else if (execCode(OP_ERRD_SET)) begin
      errorDisplayEnable <= 1'b1;
    end else if (execCode(OP_ERRD_CLR)) begin
      errorDisplayEnable <= 1'b0;
    end
  end

  // Printer enable is a one-slot low pulse following T12 of any Bx code
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      printerEnable_n <= 1'b1;
    end else begin
      printerEnable_n <= !(execSlot && (irMid == GRP_PRINT));
    end
  end

  // ****************************************************
  // Branch sequencing
  // ****************************************************
  assign decoderInhibit = (stage != SEQ_IDLE);
  assign isConst = (condDigit == DIG_LOAD_A) || (condDigit == DIG_LOAD_C);
  // Digits 1..D pick an external condition; 0 always passes
  assign testPass = (condDigit == DIG_UNCOND) || testCond[condDigit];
  assign takenBranch = incrementInhibit && !isConst;

  // Stage leaves idle at T12, then advances at cycle boundaries: three slots plus two whole cycles
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stage <= SEQ_IDLE;
      condDigit <= 4'h0;
    end else begin
      unique case (stage)
        SEQ_IDLE: begin
          if (execSlot && (irMid == GRP_BRANCH)) begin
            stage <= SEQ_FIRST;
            condDigit <= irLow;
          end
        end
        SEQ_FIRST: begin
          if (firstTimeSlot) begin
            stage <= SEQ_SECOND;
          end
        end
        SEQ_SECOND: begin
          if (firstTimeSlot) begin
            stage <= SEQ_THIRD;
          end
        end
        SEQ_THIRD: begin
          if (firstTimeSlot) begin
            stage <= SEQ_IDLE;
          end
        end
      endcase
    end
  end

  // Increment inhibit: whole third cycle for constants, from T12 for a pass
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      incrementInhibit <= 1'b0;
    end else if (firstTimeSlot) begin
      incrementInhibit <= (stage == SEQ_SECOND) && isConst;
    end else if (run && (stage == SEQ_THIRD) && (timeSlot == SLOT_EXEC) && testPass) begin
      incrementInhibit <= 1'b1;
    end
  end

  // Address source leaves the panel only for a taken branch
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      addrSourceSelect_n <= 1'b1;
    end else if (firstTimeSlot) begin
      addrSourceSelect_n <= 1'b1;
    end else if (run && (stage == SEQ_THIRD) && (timeSlot == SLOT_EXEC) && testPass && !isConst) begin
      addrSourceSelect_n <= 1'b0;
    end
  end

  // Constant path held for the whole third cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      constantPathSelect <= 1'b0;
    end else if (firstTimeSlot) begin
      constantPathSelect <= (stage == SEQ_SECOND) && isConst;
    end
  end

  // Strobes are decoded from state and slot, one slot wide
  assign seqAddrClear = run && (stage == SEQ_THIRD) && takenBranch && (timeSlot == SLOT_CLEAR);
  assign seqAddrLoad = run && (stage == SEQ_THIRD) && takenBranch && (timeSlot == SLOT_STEP);
  assign aConstantClear = run && constantPathSelect && (condDigit == DIG_LOAD_A)
                          && (timeSlot == SLOT_CLEAR);
  assign cConstantClear = run && constantPathSelect && (condDigit == DIG_LOAD_C)
                          && (timeSlot == SLOT_CLEAR);
  assign aConstantLoad = run && constantPathSelect && (condDigit == DIG_LOAD_A)
                         && (timeSlot == SLOT_STEP);
  assign cConstantLoad = run && constantPathSelect && (condDigit == DIG_LOAD_C)
                         && (timeSlot == SLOT_STEP);

  // ****************************************************
  // Microcode address counter
  // ****************************************************
  // Branch target is the low, middle and lower four high bits
  assign addrMux = addrSourceSelect_n ? panelAddrS : {irHigh[NIB_W-1:0], irMid, irLow};

  // Sequence clear/load beat step; a panel load outside idle, or at a step, is lost
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      romAddr <= RST_ADDR;
    end else if (seqAddrClear) begin
      romAddr <= '0;
    end else if (seqAddrLoad) begin
      romAddr <= addrMux;
    end else if (run && (timeSlot == SLOT_STEP) && !incrementInhibit) begin
      romAddr <= romAddr + 12'h001;
    end else if (panelLoadEv && (stage == SEQ_IDLE)) begin
      romAddr <= addrMux;
    end
  end

  // ****************************************************
  // Checks
  // ****************************************************
  logic [5:0] seqLen;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      seqLen <= 6'h00;
    end else begin
      seqLen <= decoderInhibit ? seqLen + 6'h01 : 6'h00;
    end
  end

  a_seq_three_cycles: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(decoderInhibit) |-> seqLen == SEQ_INHIBIT_SLOTS)
    else $error("branch sequence length wrong");

  a_trdy_set: assert property (@(posedge mclk) disable iff (!rst_n)
    execCode(OP_TRDY_SET) |=> transmitReadyFlag)
    else $error("transmit ready not set");

  a_txen_on: assert property (@(posedge mclk) disable iff (!rst_n)
    execCode(OP_TXEN_ON) |=> !transmitEnable_n ##1 $stable(transmitEnable_n))
    else $error("transmit enable not asserted");

  a_errd_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    execCode(OP_ERRD_CLR) |=> !errorDisplayEnable)
    else $error("error display not cleared");

  a_print_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
    (execSlot && (irMid == GRP_PRINT)) |=> !printerEnable_n ##1 printerEnable_n)
    else $error("printer enable pulse wrong");

  a_taken_load: assert property (@(posedge mclk) disable iff (!rst_n)
    seqAddrClear |=> (romAddr == 12'h000) && seqAddrLoad ##1 romAddr == $past(addrMux))
    else $error("branch target not loaded");

  a_const_keeps_addr: assert property (@(posedge mclk) disable iff (!rst_n)
    (constantPathSelect && (timeSlot == SLOT_FETCH) && run) |-> incrementInhibit
    ##3 !seqAddrLoad ##1 (romAddr == $past(romAddr, 4)))
    else $error("constant load moved the address");

  a_step_inc: assert property (@(posedge mclk) disable iff (!rst_n)
    (run && (timeSlot == SLOT_STEP) && !incrementInhibit) |=> romAddr == $past(romAddr) + 12'h001)
    else $error("address did not step");

  a_halt_stop: assert property (@(posedge mclk) disable iff (!rst_n)
    execCode(OP_HALT) ##1 !panelRunEv |=> $stable(timeSlot))
    else $error("timing counter kept running");

  c_taken_branch: cover property (@(posedge mclk) disable iff (!rst_n) seqAddrLoad);
  c_failed_branch: cover property (@(posedge mclk) disable iff (!rst_n)
    $fell(decoderInhibit) && !$past(incrementInhibit) && !$past(constantPathSelect));
  c_const_a: cover property (@(posedge mclk) disable iff (!rst_n) aConstantLoad);
  c_halt: cover property (@(posedge mclk) disable iff (!rst_n) $rose(halted));

endmodule

// ### microcode_rom_model.sv
`timescale 1ns/1ps
// ****************************************************
// Microcode instruction storage model
// ****************************************************
module microcode_rom_model
  import branch_seq_pkg::*;
(
  input wire logic [ADDR_W-1:0] romAddr,
  output logic [7:0] romData
);
  logic [7:0] mem [0:(1<<ADDR_W)-1];

  // Unused words hold a harmless code so stray fetches do nothing visible
  initial begin
    for (int i = 0; i < (1 << ADDR_W); i++) begin
      mem[i] = 8'h01;
    end
  end

  // Asynchronous read; word is settled long before the slot-11 sample
  assign romData = mem[romAddr];
endmodule

// ### microcode_branch_sequencer_tb.sv
`timescale 1ns/1ps
// ****************************************************
// Self-checking bench for the branch sequencer
// ****************************************************
module microcode_branch_sequencer_tb
  import branch_seq_pkg::*;
;
  logic mclk, rst_n, panelLoad, panelRun;
  logic [7:0] romData, instruction;
  logic [15:0] testCond;
  logic [ADDR_W-1:0] panelAddr, romAddr;
  logic [SLOT_W-1:0] timeSlot;
  logic halted, transmitReadyFlag, variableFieldInhibit, transmitEnable_n, errorDisplayEnable;
  logic printerEnable_n, decoderInhibit, thirdCycleLatchBlock_n, highLatchLoad, incrementInhibit;
  logic seqAddrClear, seqAddrLoad, addrSourceSelect_n, aConstantClear, cConstantClear;
  logic aConstantLoad, cConstantLoad, constantPathSelect;
  logic [CONST_W-1:0] constantValue;
  int fail_count = 0;
  int comparisons = 0;
  // Single codes in order, and flags {ready, inhibit, enable_n, errdisp} after each
  localparam logic [7:0] SINGLE_OPS [8] = '{OP_TRDY_SET, OP_TXEN_ON, OP_VARI_SET, OP_ERRD_SET,
                                            OP_TRDY_CLR, OP_TXEN_OFF, OP_VARI_CLR, OP_ERRD_CLR};
  localparam logic [3:0] SINGLE_FLAGS [8] = '{4'ha, 4'h8, 4'hc, 4'hd, 4'h5, 4'h7, 4'h3, 4'h2};

  microcode_branch_sequencer i_microcode_branch_sequencer (.mclk(mclk), .rst_n(rst_n),
    .romData(romData), .testCond(testCond), .panelAddr(panelAddr), .panelLoad(panelLoad),
    .panelRun(panelRun), .romAddr(romAddr), .instruction(instruction), .timeSlot(timeSlot),
    .halted(halted), .transmitReadyFlag(transmitReadyFlag), .variableFieldInhibit(variableFieldInhibit),
    .transmitEnable_n(transmitEnable_n), .errorDisplayEnable(errorDisplayEnable),
    .printerEnable_n(printerEnable_n), .decoderInhibit(decoderInhibit),
    .thirdCycleLatchBlock_n(thirdCycleLatchBlock_n), .highLatchLoad(highLatchLoad),
    .incrementInhibit(incrementInhibit), .seqAddrClear(seqAddrClear), .seqAddrLoad(seqAddrLoad),
    .addrSourceSelect_n(addrSourceSelect_n), .aConstantClear(aConstantClear),
    .cConstantClear(cConstantClear), .aConstantLoad(aConstantLoad), .cConstantLoad(cConstantLoad),
    .constantPathSelect(constantPathSelect), .constantValue(constantValue));

  microcode_rom_model i_microcode_rom_model (.romAddr(romAddr), .romData(romData));

  // 125 MHz clock
  initial mclk = 1'b0;
  always #4 mclk = ~mclk;

  // ****************************************************
  // Checking and timing helpers
  // ****************************************************
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Always moves on at least one clock, so repeated calls reach the next cycle
  task automatic wait_slot(input logic [3:0] s);
    int n;
    n = 0;
    @(negedge mclk);
    while (timeSlot !== s && n < 40) begin
      @(negedge mclk);
      n++;
    end
    chk("timeSlot reached", {12'h000, s}, {12'h000, timeSlot});
  endtask

  task automatic put(input logic [11:0] a, input logic [7:0] d);
    i_microcode_rom_model.mem[a] = d;
  endtask

  task automatic chk_reset();
    chk("romAddr", {4'h0, RST_ADDR}, {4'h0, romAddr});
    chk("instruction", 16'h0000, {8'h00, instruction});
    chk("reset levels", 16'h000b, {9'h000, halted, transmitReadyFlag, variableFieldInhibit,
        transmitEnable_n, errorDisplayEnable, printerEnable_n, addrSourceSelect_n});
  endtask

  // One three-cycle group: checked from the slot after decode to the end of the third cycle
  task automatic run_seq(input logic [7:0] op, input logic [12:0] val, input logic [11:0] addrEnd,
                         input logic taken);
    logic isConst;
    isConst = (op[3:0] == DIG_LOAD_A) || (op[3:0] == DIG_LOAD_C);
    wait_slot(SLOT_CLEAR);
    chk("group opcode", {8'h00, op}, {8'h00, instruction});
    chk("decoderInhibit", 16'h0001, {15'h0, decoderInhibit});
    chk("printerEnable_n", 16'h0001, {15'h0, printerEnable_n});
    wait_slot(SLOT_CLEAR);
    chk("second word", {8'h00, val[7:0]}, {8'h00, instruction});
    chk("decoderInhibit", 16'h0001, {15'h0, decoderInhibit});
    wait_slot(SLOT_FIRST);
    chk("thirdCycleLatchBlock_n", 16'h0000, {15'h0, thirdCycleLatchBlock_n});
    chk("constantPathSelect", {15'h0, isConst}, {15'h0, constantPathSelect});
    chk("early incrementInhibit", {15'h0, isConst}, {15'h0, incrementInhibit});
    wait_slot(SLOT_FETCH);
    chk("highLatchLoad", 16'h0001, {15'h0, highLatchLoad});
    wait_slot(SLOT_CLEAR);
    chk("incrementInhibit", {15'h0, taken | isConst}, {15'h0, incrementInhibit});
    chk("seqAddrClear", {15'h0, taken}, {15'h0, seqAddrClear});
    chk("addrSourceSelect_n", {15'h0, ~taken}, {15'h0, addrSourceSelect_n});
    chk("const clears", {14'h0, op[3:0] == DIG_LOAD_A, op[3:0] == DIG_LOAD_C},
        {14'h0, aConstantClear, cConstantClear});
    wait_slot(SLOT_STEP);
    chk("seqAddrLoad", {15'h0, taken}, {15'h0, seqAddrLoad});
    chk("const loads", {14'h0, op[3:0] == DIG_LOAD_A, op[3:0] == DIG_LOAD_C},
        {14'h0, aConstantLoad, cConstantLoad});
    wait_slot(SLOT_LAST);
    chk("romAddr after group", {4'h0, addrEnd}, {4'h0, romAddr});
    if (isConst) begin
      chk("constantValue", {3'h0, val}, {3'h0, constantValue});
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    rst_n = 1'b0;
    testCond = 16'h2000; // Condition 13 true, condition 1 false
    panelAddr = 12'h000;
    panelLoad = 1'b0;
    panelRun = 1'b0;
    // Let the storage model fill its default words first, or it may overwrite the program
    #1;
    for (int i = 0; i < 8; i++) begin
      put(i[11:0], SINGLE_OPS[i]);
    end
    put(12'h008, 8'h90); put(12'h009, 8'h34); put(12'h00a, 8'h01);
    put(12'h134, 8'h9e); put(12'h135, 8'ha5); put(12'h136, 8'h1b);
    put(12'h137, 8'h9f); put(12'h138, 8'h00); put(12'h139, 8'h10);
    put(12'h13a, 8'h91); put(12'h13b, 8'h44); put(12'h13c, 8'h02); put(12'h13d, OP_HALT);
    put(12'h055, 8'h9d); put(12'h056, 8'h20); put(12'h057, 8'h03); put(12'h320, OP_HALT);
    repeat (2) @(negedge mclk);
    chk_reset();
    rst_n = 1'b1;
    // Single codes, each visible in the slot after its execute edge
    for (int i = 0; i < 8; i++) begin
      wait_slot(SLOT_CLEAR);
      chk("instruction", {8'h00, SINGLE_OPS[i]}, {8'h00, instruction});
      chk("printerEnable_n", 16'h0000, {15'h0, printerEnable_n});
      chk("flags", {12'h000, SINGLE_FLAGS[i]}, {12'h000, transmitReadyFlag, variableFieldInhibit,
          transmitEnable_n, errorDisplayEnable});
    end
    run_seq(8'h90, 13'h0134, 12'h134, 1'b1);
    run_seq(8'h9e, 13'h1ba5, 12'h136, 1'b0);
    wait_slot(SLOT_CLEAR);
    run_seq(8'h9f, 13'h1000, 12'h139, 1'b0);
    wait_slot(SLOT_CLEAR);
    run_seq(8'h91, 13'h0244, 12'h13d, 1'b0);
    // Halt freezes the slot counter and the address
    wait_slot(SLOT_CLEAR);
    repeat (4) @(negedge mclk);
    chk("halted", 16'h0001, {15'h0, halted});
    chk("frozen slot", {12'h000, SLOT_CLEAR}, {12'h000, timeSlot});
    chk("frozen romAddr", 16'h013d, {4'h0, romAddr});
    panelAddr = 12'h055;
    panelRun = 1'b1;
    repeat (8) @(negedge mclk);
    chk("halted after run", 16'h0000, {15'h0, halted});
    panelRun = 1'b0;
    // Manual load early in a cycle, clear of the slot-14 increment
    wait_slot(SLOT_FIRST);
    panelLoad = 1'b1;
    repeat (8) @(negedge mclk);
    chk("panel romAddr", 16'h0055, {4'h0, romAddr});
    panelLoad = 1'b0;
    run_seq(8'h9d, 13'h0320, 12'h320, 1'b1);
    wait_slot(SLOT_CLEAR);
    chk("halt at target", 16'h0100, {7'h0, halted, instruction});
    // Reset while halted at the target restores the address, instruction and flag levels
    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    chk_reset();
    rst_n = 1'b1;
    // Timing counter restarts from the first slot and stays running
    repeat (2) @(negedge mclk);
    chk("slot after reset", 16'h0002, {12'h000, timeSlot});
    chk("halted after reset", 16'h0000, {15'h0, halted});
    print_verdict();
  end

  // Watchdog: the sequence needs well under 2,000 clocks; 25,000 means a hang
  initial begin
    #200000;
    fail_count++;
    $display("ERROR watchdog expected finish seen timeout");
    print_verdict();
  end
endmodule
